// ### hw/hid_pkg.sv
// package: constants and types of the hart input diagnostic block
package hid_pkg;
    localparam int NCH = 2;
    localparam int AW  = 8;
    localparam int VW  = 16;
    localparam int RW  = 16;
    // register byte addresses
    localparam logic [AW-1:0] A_CTRL  = 8'h00;
    localparam logic [AW-1:0] A_CHCFG = 8'h04;
    localparam logic [AW-1:0] A_HILIM = 8'h08;
    localparam logic [AW-1:0] A_LOLIM = 8'h0c;
    localparam logic [AW-1:0] A_DIAG  = 8'h10;
    localparam logic [AW-1:0] A_INFO  = 8'h14;
    localparam logic [AW-1:0] A_RESP  = 8'h18;
    localparam logic [AW-1:0] A_VAL   = 8'h1c;
    localparam logic [AW-1:0] A_PV    = 8'h20;
    localparam logic [AW-1:0] A_IDENT = 8'h24;
    // control register fields
    localparam int C_DIAG_IE = 0;
    localparam int C_LIM_IE  = 1;
    localparam int C_EOC_IE  = 2;
    localparam int C_GRP     = 4;
    localparam int C_WB      = 6;
    localparam int C_IT      = 8;
    localparam int CTRL_W    = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h200;
    localparam logic [1:0] IT_2P5  = 2'h0;
    localparam logic [1:0] IT_16P6 = 2'h1;
    localparam logic [1:0] IT_20   = 2'h2;
    localparam logic [1:0] IT_100  = 2'h3;
    // channel configuration fields, one byte per channel
    localparam int CF_W    = 8;
    localparam int CF_MODE = 0;
    localparam int CF_HART = 2;
    localparam int CF_R0   = 3;
    localparam int CF_RES  = 4;
    localparam int RES_W   = 4;
    localparam logic [1:0] mode_off               = 2'h0;
    localparam logic [1:0] two_wire_current_mode  = 2'h1;
    localparam logic [1:0] four_wire_current_mode = 2'h2;
    localparam logic [CF_W-1:0] CF_RST = 8'h05;
    // limits, defaults at overflow and underflow
    localparam logic [31:0] HI_RST = 32'h7fff_7fff;
    localparam logic [31:0] LO_RST = 32'h8001_8001;
    // diagnostic flags, two bits each (one per channel)
    localparam int D_PCHG = 0;
    localparam int D_GRP  = 2;
    localparam int D_WB   = 4;
    localparam int D_WARN = 6;
    localparam int D_W    = 8;
    localparam logic [D_W-1:0] FAULT_MASK = 8'h3f;
    // hardware interrupt info bytes
    localparam int INFO_ACK = 0;
    localparam int INFO_HI  = 0;
    localparam int INFO_LO  = 8;
    localparam logic [31:0] INFO_EOC = 32'hffff_fcfc;
    // hart commands and status bits
    localparam logic [7:0] CMD_ID  = 8'h00;
    localparam logic [7:0] CMD_TAG = 8'h0d;
    localparam logic [7:0] CMD_PV  = 8'h01;
    localparam int ST_COMM = 7;
    localparam int DEV_CHG = 6;
    localparam logic [1:0] STG_ID  = 2'h0;
    localparam logic [1:0] STG_TAG = 2'h1;
    localparam logic [1:0] STG_RUN = 2'h2;
    // open circuit threshold, 3.6 mA on the live-zero scale
    localparam logic signed [VW-1:0] WB_CODE = 16'shfd4d;

    typedef enum logic {S_IDLE, S_BUSY} hid_seq_t;

    typedef struct packed {
        logic [CTRL_W-1:0]     ctrl;
        logic [NCH*CF_W-1:0]   cfg;
        logic [31:0]           hi;
        logic [31:0]           lo;
        logic [31:0]           info;
        logic [31:0]           resp;
        logic [31:0]           val;
        logic [31:0]           pv;
        logic [31:0]           ident;
        logic [31:0]           rdata;
        logic [D_W-1:0]        diag;
        logic                  pend;
        logic [2*NCH-1:0]      stage;
        hid_seq_t              seq;
        logic                  sch;
        logic                  cch;
        logic [7:0]            cmd;
    } hid_st_t;

    localparam hid_st_t ST_RST = '{ctrl: CTRL_RST, cfg: {NCH{CF_RST}}, hi: HI_RST, lo: LO_RST,
                                   seq: S_IDLE, default: '0};
endpackage

// ### hw/hid_chan_mon.sv
// channel monitor: resolution, limit and open circuit check of one sample
`timescale 1ns/10ps
module hid_chan_mon
    import hid_pkg::*;
#(
    parameter int VW_P = VW
) (
    // sample and configuration
    input  wire logic signed [VW_P-1:0] code,
    input  wire logic [CF_W-1:0]        cfg,
    // limits
    input  wire logic signed [VW_P-1:0] hi_lim,
    input  wire logic signed [VW_P-1:0] lo_lim,
    // results
    output logic signed [VW_P-1:0]      val,
    output logic                        hi_viol,
    output logic                        lo_viol,
    output logic                        wire_brk
);
    logic on;

    always_comb begin
        on       = cfg[CF_MODE +: 2] != mode_off;
        val      = code & ({VW_P{1'b1}} << cfg[CF_RES +: RES_W]); // [RULE9] [RULE10]
        hi_viol  = on && (code > hi_lim);
        lo_viol  = on && (code < lo_lim);
        wire_brk = on && !cfg[CF_R0] && (code <= WB_CODE); // [RULE13] [RULE14]
    end
endmodule

// ### hw/hid_top.sv
// hart input diagnostics and interrupts with apb registers
//
// Summary of operation
// (RULE1) device reports parameter change: flag channel diagnostic when group diagnostics on
// (RULE2) communication or command error in a hart reply raises group error
// (RULE3) reply status bytes stored unchanged in readable response register
// (RULE4) command error is a warning, kept apart from device status and faults
// (RULE5) each interrupt source has its own enable bit
// (RULE6) limit and end-of-cycle hardware interrupts, separately enabled
// (RULE7) limit info: byte 0 high, byte 1 low, bit per channel, rest zero
// (RULE8) end-of-cycle info: all non-channel bits of four bytes set
// (RULE9) values are signed sixteen-bit words
// (RULE10) resolution set per channel
// (RULE11) per channel mode: off, two- or four-wire, with or without hart
// (RULE12) no hart on a channel using the zero-based range
// (RULE13) no open circuit check in the zero-based range
// (RULE14) live-zero current at or below threshold is open circuit, diagnostic interrupt
// (RULE15) reset defaults: hart active, default integration, diagnostics, interrupts off
// (RULE16) host should pick longest integration time on hart channels
// (RULE17) hart start-up sends command 0 then 13, identification data stored
// (RULE18) running channels repeat command 1, primary variable stored
// (RULE19) zero-based range accepted only with four-wire mode
// (RULE20) interrupt held until acknowledged; unread limit info never overwritten
`timescale 1ns/10ps
module hid_top
    import hid_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // converter samples
    input  wire logic              adc_valid,
    input  wire logic              adc_chan,
    input  wire logic [VW-1:0]     adc_code,
    input  wire logic              cycle_end,
    // hart modem
    output logic                   hart_req,
    output logic [7:0]             hart_cmd,
    output logic                   hart_chan,
    input  wire logic              hart_done,
    input  wire logic [31:0]       hart_rsp_data,
    input  wire logic [7:0]        hart_comm_st,
    input  wire logic [7:0]        hart_dev_st,
    // interrupts and front-end setup
    output logic                   diag_irq,
    output logic                   hw_irq,
    output logic [1:0]             int_time_sel
);
    hid_st_t                st_ff;
    hid_st_t                nxt_st;
    logic                   wr;
    logic                   ack;
    logic                   rsp;
    logic                   hact_cur;
    logic [RW-1:0]          rsp_st;
    logic [VW-1:0]          pv_in;
    logic [CF_W-1:0]        m_cfg;
    logic signed [VW-1:0]   m_val;
    logic                   m_hi;
    logic                   m_lo;
    logic                   m_wb;
    logic                   lim_ev;

    function automatic logic hit(input logic [AW-1:0] a);
        return a inside {A_CTRL, A_CHCFG, A_HILIM, A_LOLIM, A_DIAG, A_INFO, A_RESP, A_VAL, A_PV, A_IDENT};
    endfunction

    // hart runs only in an enabled mode with the live-zero range
    function automatic logic hact(input logic [CF_W-1:0] c);
        return c[CF_MODE +: 2] != mode_off && c[CF_HART] && !c[CF_R0]; // [RULE11] [RULE12]
    endfunction

    function automatic logic [7:0] cmd_of(input logic [1:0] stg);
        case (stg)
            STG_ID:  return CMD_ID; // [RULE17]
            STG_TAG: return CMD_TAG; // [RULE17]
            default: return CMD_PV; // [RULE18]
        endcase
    endfunction

    function automatic logic [31:0] rd(input hid_st_t s, input logic [AW-1:0] a);
        case (a)
            A_CTRL:  return {{(32-CTRL_W){1'b0}}, s.ctrl};
            A_CHCFG: return {{(32-NCH*CF_W){1'b0}}, s.cfg};
            A_HILIM: return s.hi;
            A_LOLIM: return s.lo;
            A_DIAG:  return {{(32-D_W){1'b0}}, s.diag};
            A_INFO:  return s.info;
            A_RESP:  return s.resp;
            A_VAL:   return s.val;
            A_PV:    return s.pv;
            A_IDENT: return s.ident;
            default: return 32'h0000_0000;
        endcase
    endfunction

    assign wr       = psel && penable && pwrite && hit(paddr);
    assign ack      = wr && paddr == A_INFO && pwdata[INFO_ACK];
    assign rsp      = hart_done && st_ff.seq == S_BUSY;
    assign rsp_st   = {hart_dev_st, hart_comm_st};
    assign pv_in    = hart_rsp_data[VW-1:0];
    assign m_cfg    = st_ff.cfg[adc_chan*CF_W +: CF_W];
    assign hact_cur = hact(st_ff.cfg[st_ff.sch*CF_W +: CF_W]);
    assign lim_ev   = adc_valid && st_ff.ctrl[C_LIM_IE] && (m_hi || m_lo); // [RULE5] [RULE6]

    hid_chan_mon #(
        .VW_P     (VW)
    ) u_mon (
        .code     (adc_code),
        .cfg      (m_cfg),
        .hi_lim   (st_ff.hi[adc_chan*VW +: VW]),
        .lo_lim   (st_ff.lo[adc_chan*VW +: VW]),
        .val      (m_val),
        .hi_viol  (m_hi),
        .lo_viol  (m_lo),
        .wire_brk (m_wb)
    );

    always_comb begin
        logic [D_W-1:0]  dset;
        logic [D_W-1:0]  dclr;
        logic [CF_W-1:0] c;
        logic            ch;
        logic            free;
        logic            comm;
        logic            cerr;
        dset   = '0;
        dclr   = '0;
        c      = '0;
        ch     = st_ff.cch;
        free   = !st_ff.pend || ack;
        comm   = hart_comm_st[ST_COMM];
        cerr   = !comm && hart_comm_st != 8'h00;
        nxt_st = st_ff;
        // register access
        if (psel && !penable) begin
            nxt_st.rdata = rd(st_ff, paddr);
        end
        if (wr) begin
            case (paddr)
                A_CTRL:  nxt_st.ctrl = pwdata[CTRL_W-1:0]; // [RULE5]
                A_CHCFG: begin
                    for (int i = 0; i < NCH; i++) begin
                        c = pwdata[i*CF_W +: CF_W];
                        if (c[CF_MODE +: 2] != four_wire_current_mode) begin
                            c[CF_R0] = 1'b0; // [RULE19]
                        end
                        nxt_st.cfg[i*CF_W +: CF_W] = c; // [RULE10] [RULE11]
                    end
                end
                A_HILIM: nxt_st.hi = pwdata;
                A_LOLIM: nxt_st.lo = pwdata;
                A_DIAG:  dclr = pwdata[D_W-1:0];
                default: ;
            endcase
        end
        if (ack) begin
            nxt_st.pend = 1'b0;
            nxt_st.info = '0;
        end
        // samples and hardware interrupt info
        if (adc_valid) begin
            nxt_st.val[adc_chan*VW +: VW] = m_val; // [RULE9]
            if (m_wb && st_ff.ctrl[C_WB + adc_chan]) begin
                dset[D_WB + adc_chan] = 1'b1; // [RULE14]
            end
        end
        if (lim_ev && free) begin
            nxt_st.info = '0; // [RULE7]
            nxt_st.info[INFO_HI + adc_chan] = m_hi; // [RULE7]
            nxt_st.info[INFO_LO + adc_chan] = m_lo; // [RULE7]
            nxt_st.pend = 1'b1; // [RULE20]
        end else if (cycle_end && st_ff.ctrl[C_EOC_IE] && free) begin
            nxt_st.info = INFO_EOC; // [RULE8]
            nxt_st.pend = 1'b1; // [RULE6]
        end
        // hart command sequencer, channels served in turn
        case (st_ff.seq)
            S_IDLE: begin
                if (hact_cur) begin
                    nxt_st.cmd = cmd_of(st_ff.stage[st_ff.sch*2 +: 2]); // [RULE17] [RULE18]
                    nxt_st.cch = st_ff.sch;
                    nxt_st.seq = S_BUSY;
                end else begin
                    nxt_st.stage[st_ff.sch*2 +: 2] = STG_ID; // [RULE12]
                    nxt_st.sch = ~st_ff.sch;
                end
            end
            S_BUSY: begin
                if (hart_done) begin
                    nxt_st.resp[ch*RW +: RW] = rsp_st; // [RULE3]
                    if ((comm || cerr) && st_ff.ctrl[C_GRP + ch]) begin
                        dset[D_GRP + ch] = 1'b1; // [RULE2]
                    end
                    if (cerr) begin
                        dset[D_WARN + ch] = 1'b1; // [RULE4]
                    end
                    if (!comm && hart_dev_st[DEV_CHG] && st_ff.ctrl[C_GRP + ch]) begin
                        dset[D_PCHG + ch] = 1'b1; // [RULE1]
                    end
                    if (!comm) begin
                        case (st_ff.cmd)
                            CMD_ID: begin
                                nxt_st.ident[ch*RW +: 8]     = hart_rsp_data[7:0]; // [RULE17]
                                nxt_st.stage[ch*2 +: 2]      = STG_TAG;
                            end
                            CMD_TAG: begin
                                nxt_st.ident[ch*RW + 8 +: 8] = hart_rsp_data[7:0]; // [RULE17]
                                nxt_st.stage[ch*2 +: 2]      = STG_RUN;
                            end
                            default: nxt_st.pv[ch*RW +: RW] = pv_in; // [RULE18]
                        endcase
                    end
                    nxt_st.seq = S_IDLE;
                    nxt_st.sch = ~ch;
                end
            end
            default: nxt_st.seq = S_IDLE;
        endcase
        // set wins over a clear in the same cycle
        nxt_st.diag = (st_ff.diag & ~dclr) | dset;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_RST; // [RULE15]
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata       = st_ff.rdata;
    assign pready       = 1'b1;
    assign pslverr      = psel && penable && !hit(paddr);
    assign hart_req     = st_ff.seq == S_BUSY;
    assign hart_cmd     = st_ff.cmd;
    assign hart_chan    = st_ff.cch;
    assign hw_irq       = st_ff.pend; // [RULE20]
    assign diag_irq     = st_ff.ctrl[C_DIAG_IE] && |(st_ff.diag & FAULT_MASK); // [RULE4] [RULE14]
    assign int_time_sel = st_ff.ctrl[C_IT +: 2];

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pchg;
        rsp && !hart_comm_st[ST_COMM] && hart_dev_st[DEV_CHG] && st_ff.ctrl[C_GRP + st_ff.cch]
        |=> st_ff.diag[D_PCHG + st_ff.cch];
    endproperty
    a_pchg: assert property (p_pchg) else $error("parameter change flag missing"); // [RULE1]

    property p_grp;
        rsp && hart_comm_st != 8'h00 && st_ff.ctrl[C_GRP + st_ff.cch] |=> st_ff.diag[D_GRP + st_ff.cch];
    endproperty
    a_grp: assert property (p_grp) else $error("group error flag missing"); // [RULE2]

    property p_resp;
        rsp |=> st_ff.resp[st_ff.cch*RW +: RW] == $past(rsp_st);
    endproperty
    a_resp: assert property (p_resp) else $error("status bytes not stored unchanged"); // [RULE3]

    property p_warn;
        (st_ff.diag & FAULT_MASK) == '0 |-> !diag_irq;
    endproperty
    a_warn: assert property (p_warn) else $error("warning raised a diagnostic interrupt"); // [RULE4]

    property p_ie;
        !st_ff.ctrl[C_LIM_IE] && !st_ff.ctrl[C_EOC_IE] && !hw_irq |=> !hw_irq;
    endproperty
    a_ie: assert property (p_ie) else $error("disabled source raised interrupt"); // [RULE5] [RULE6]

    property p_lim;
        lim_ev && !hw_irq |=> hw_irq && st_ff.info[31:16] == 16'h0000 && st_ff.info[7:2] == 6'h00
            && st_ff.info[15:10] == 6'h00 && st_ff.info[INFO_HI + $past(adc_chan)] == $past(m_hi);
    endproperty
    a_lim: assert property (p_lim) else $error("limit info bytes wrong"); // [RULE7]

    property p_eoc;
        cycle_end && st_ff.ctrl[C_EOC_IE] && !hw_irq && !lim_ev |=> st_ff.info == INFO_EOC;
    endproperty
    a_eoc: assert property (p_eoc) else $error("end of cycle info wrong"); // [RULE8]

    property p_hold;
        hw_irq && !ack |=> hw_irq && $stable(st_ff.info);
    endproperty
    a_hold: assert property (p_hold) else $error("pending info lost"); // [RULE20]

    property p_nohart;
        $rose(hart_req) |-> $past(hact_cur);
    endproperty
    a_nohart: assert property (p_nohart) else $error("hart on inactive channel"); // [RULE12]

    property p_r0;
        adc_valid && m_cfg[CF_R0] |-> !m_wb;
    endproperty
    a_r0: assert property (p_r0) else $error("open circuit in zero range"); // [RULE13]

    property p_wb;
        adc_valid && m_wb && st_ff.ctrl[C_WB + adc_chan] |=> st_ff.diag[D_WB + $past(adc_chan)];
    endproperty
    a_wb: assert property (p_wb) else $error("open circuit not flagged"); // [RULE14]

    property p_start;
        $rose(hart_req) && st_ff.stage[hart_chan*2 +: 2] == STG_ID |-> hart_cmd == CMD_ID;
    endproperty
    a_start: assert property (p_start) else $error("start-up did not send identify"); // [RULE17]

    property p_pv;
        rsp && st_ff.cmd == CMD_PV && !hart_comm_st[ST_COMM] |=> st_ff.pv[st_ff.cch*RW +: RW] == $past(pv_in);
    endproperty
    a_pv: assert property (p_pv) else $error("primary variable not stored"); // [RULE18]

    property p_r19;
        !(st_ff.cfg[CF_R0] && st_ff.cfg[CF_MODE +: 2] != four_wire_current_mode)
        && !(st_ff.cfg[CF_W + CF_R0] && st_ff.cfg[CF_W + CF_MODE +: 2] != four_wire_current_mode);
    endproperty
    a_r19: assert property (p_r19) else $error("zero range without four-wire"); // [RULE19]

    property p_c_lim;
        lim_ev && !hw_irq;
    endproperty
    c_lim: cover property (p_c_lim);

    property p_c_eoc;
        cycle_end && st_ff.ctrl[C_EOC_IE] && !hw_irq;
    endproperty
    c_eoc: cover property (p_c_eoc);

    property p_c_pv;
        rsp && st_ff.cmd == CMD_PV;
    endproperty
    c_pv: cover property (p_c_pv);
endmodule

// ### tb/hid_hart_dev.sv
// hart field transmitter model: answers each command after a set latency
`timescale 1ns/10ps
module hid_hart_dev
    import hid_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // command from the block
    input  wire logic        hart_req,
    input  wire logic [7:0]  hart_cmd,
    input  wire logic        hart_chan,
    // reply latency and status bytes chosen by the bench
    input  wire logic [3:0]  lat,
    input  wire logic [7:0]  comm_st,
    input  wire logic [7:0]  dev_st,
    // reply
    output logic             hart_done,
    output logic [31:0]      hart_rsp_data,
    output logic [7:0]       hart_comm_st,
    output logic [7:0]       hart_dev_st
);
    logic [3:0]  cnt_ff;
    logic [31:0] junk_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff    <= 4'h0;
            hart_done <= 1'b0;
            junk_ff   <= 32'h0;
        end else begin
            junk_ff   <= junk_ff + 32'h9e37_79b9;
            hart_done <= 1'b0;
            cnt_ff    <= 4'h0;
            if (hart_req && !hart_done) begin
                cnt_ff    <= cnt_ff + 4'h1;
                hart_done <= (cnt_ff == lat);
            end
        end
    end
    // reply lines change every cycle outside the reply
    assign hart_rsp_data = hart_done ? {16'h0, 7'h18, hart_chan, hart_cmd + 8'h11} : ~junk_ff;
    assign hart_comm_st  = hart_done ? comm_st : ~junk_ff[7:0];
    assign hart_dev_st   = hart_done ? dev_st : ~junk_ff[15:8];
endmodule

// ### tb/tb_hart_input_diag_interrupts.sv
// self-checking bench of the hart input diagnostic and interrupt block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_hart_input_diag_interrupts;
    import hid_pkg::*;
    typedef struct {logic w; logic [AW-1:0] a; logic [31:0] d; logic [31:0] e; logic er;} hid_row_t;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic          adc_valid = 1'b0, adc_chan = 1'b0, cycle_end = 1'b0;
    logic          pready, pslverr, hart_req, hart_chan, hart_done, diag_irq, hw_irq, er;
    logic [7:0]    hart_cmd, hart_comm_st, hart_dev_st, p_comm = 8'h0, p_dev = 8'h0;
    logic [31:0]   pwdata = '0, prdata, hart_rsp_data, rd;
    logic [AW-1:0] paddr = '0;
    logic [VW-1:0] adc_code = '0;
    logic [1:0]    int_time_sel;
    logic [3:0]    lat = 4'h0;
    logic [8:0]    seen[$];
    int            errors = 0, n_compared = 0, sz;
    logic [8:0]    exp_seq[6] = '{9'h000, 9'h100, 9'h00d, 9'h10d, 9'h001, 9'h101};
    hid_row_t      rows[10] = '{
        '{1'b0, A_CTRL, 32'h0, 32'h200, 1'b0}, '{1'b0, A_CHCFG, 32'h0, 32'h0505, 1'b0},
        '{1'b0, A_HILIM, 32'h0, 32'h7fff_7fff, 1'b0}, '{1'b0, A_LOLIM, 32'h0, 32'h8001_8001, 1'b0},
        '{1'b0, A_DIAG, 32'h0, 32'h0, 1'b0}, '{1'b0, A_INFO, 32'h0, 32'h0, 1'b0},
        '{1'b1, A_CHCFG, 32'h0d0d, 32'h0505, 1'b0}, '{1'b1, A_CHCFG, 32'h000e, 32'h000e, 1'b0},
        '{1'b1, A_CTRL, 32'hffff_ffff, 32'h3ff, 1'b0}, '{1'b1, 8'h28, 32'h1, 32'h0, 1'b1}};

    hid_top i_hid_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .adc_valid, .adc_chan, .adc_code, .cycle_end, .hart_req, .hart_cmd, .hart_chan,
        .hart_done, .hart_rsp_data, .hart_comm_st, .hart_dev_st, .diag_irq, .hw_irq, .int_time_sel);
    hid_hart_dev i_hid_hart_dev (.pclk, .presetn, .hart_req, .hart_cmd, .hart_chan, .lat,
        .comm_st(p_comm), .dev_st(p_dev), .hart_done, .hart_rsp_data, .hart_comm_st, .hart_dev_st);

    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (hart_req === 1'b1 && hart_done === 1'b1) begin
            seen.push_back({hart_chan, hart_cmd});
        end
    end

    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            errors++;
            finish_test();
        end
        @(posedge pclk);
    endtask
    task automatic rdchk(input string nm, input logic [AW-1:0] a, input logic [31:0] ex);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(nm, ex, r)
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic adc(input logic ch, input logic [VW-1:0] c);
        adc_valid <= 1'b1;
        adc_chan  <= ch;
        adc_code  <= c;
        @(posedge pclk);
        adc_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_n(input int n);
        int k;
        for (k = 0; k < 400 && seen.size() < n; k++) @(posedge pclk);
        if (k >= 400) begin
            errors++;
            finish_test();
        end
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        `CHK("rst_out", 6'b000101, {hart_req, hw_irq, diag_irq, int_time_sel, pready})
        presetn <= 1'b1;
        wait_n(6);
        for (int i = 0; i < 6; i++) `CHK("hart_seq", exp_seq[i], seen[i])
        rdchk("ident", A_IDENT, 32'h1e11_1e11);
        rdchk("pv", A_PV, 32'h3112_3012);
        lat <= 4'h9;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
            `CHK("slverr", rows[i].er, er)
            rdchk("row", rows[i].a, rows[i].e);
        end
        repeat (20) @(posedge pclk);
        sz = seen.size();
        repeat (60) @(posedge pclk);
        `CHK("hart_skip", sz, seen.size())
        wr(A_CTRL, 32'h231);
        wr(A_CHCFG, 32'h0505);
        p_dev  <= 8'h40;
        p_comm <= 8'h05;
        wait_n(seen.size() + 4);
        `CHK("restart", ({CMD_ID, CMD_ID}), ({seen[sz][7:0], seen[sz + 1][7:0]}))
        rdchk("resp", A_RESP, 32'h4005_4005);
        rdchk("diag", A_DIAG, 32'hcf);
        `CHK("diag_irq", 1'b1, diag_irq)
        p_dev <= 8'h0;
        wr(A_CTRL, 32'h201);
        wait_n(seen.size() + 2);
        wr(A_DIAG, 32'hff);
        wait_n(seen.size() + 2);
        rdchk("warn", A_DIAG, 32'hc0);
        `CHK("warn_irq", 1'b0, diag_irq)
        p_comm <= 8'h80;
        p_dev  <= 8'h40;
        wr(A_CTRL, 32'h231);
        wr(A_DIAG, 32'hff);
        wait_n(seen.size() + 2);
        rdchk("comm", A_DIAG, 32'h0c);
        `CHK("comm_irq", 1'b1, diag_irq)
        `CHK("comm_retry", CMD_PV, seen[seen.size() - 1][7:0])
        p_comm <= 8'h0;
        p_dev  <= 8'h0;
        wait_n(seen.size() + 2);
        wr(A_DIAG, 32'hff);
        wr(A_HILIM, 32'h0064_0064);
        wr(A_LOLIM, 32'hff9c_ff9c);
        wr(A_CTRL, 32'h203);
        adc(1'b1, 16'h00c8);
        adc(1'b0, 16'hff38);
        rdchk("info_hi", A_INFO, 32'h2);
        `CHK("hw_irq", 1'b1, hw_irq)
        wr(A_INFO, 32'h1);
        `CHK("hw_ack", 1'b0, hw_irq)
        adc(1'b0, 16'hff38);
        rdchk("info_lo", A_INFO, 32'h100);
        wr(A_INFO, 32'h1);
        wr(A_CTRL, 32'h205);
        adc(1'b0, 16'h00c8);
        `CHK("lim_off", 1'b0, hw_irq)
        cycle_end <= 1'b1;
        @(posedge pclk);
        cycle_end <= 1'b0;
        rdchk("info_eoc", A_INFO, 32'hffff_fcfc);
        `CHK("hw_eoc", 1'b1, hw_irq)
        wr(A_INFO, 32'h1);
        wr(A_CHCFG, 32'h0e45);
        wr(A_CTRL, 32'h3c1);
        `CHK("it_sel", IT_100, int_time_sel)
        adc(1'b0, 16'hfd4e);
        adc(1'b1, 16'hfc00);
        rdchk("wb_none", A_DIAG, 32'h0);
        adc(1'b0, 16'hfd4d);
        rdchk("wb", A_DIAG, 32'h10);
        `CHK("wb_irq", 1'b1, diag_irq)
        adc(1'b0, 16'h1237);
        adc(1'b1, 16'h8123);
        rdchk("val", A_VAL, 32'h8123_1230);
        presetn <= 1'b0;
        @(posedge pclk);
        `CHK("rst_mid", 6'b000101, {hart_req, hw_irq, diag_irq, int_time_sel, pready})
        presetn <= 1'b1;
        rdchk("rst_ctrl", A_CTRL, 32'h200);
        rdchk("rst_cfg", A_CHCFG, 32'h0505);
        finish_test();
    end
endmodule
